// ==== cpu_fetch_execute_pipeline.sv ====
// Two-stage fetch/execute sequencer with quadrature phase generator
// Functional notes
// - Divide oscillator by four into four phases
// - Program counter increments in phase one
// - Capture fetched word phase four, execute next
// - Operand read phase two, result write phase four
// - Fetch overlaps execute, one per cycle
// - PC-changing instructions flush prefetch, two cycles
// - Byte-addressed memory, instructions on even addresses
// - Sequential fetch steps by two, bit0 zero
// - Absolute target loads PC bits 20:1
// - Relative offset doubled into byte displacement
// - Second words carry ones, decode as nop
// - Second word low 12 bits are operand
// - Skipped first word leaves second as nop
// - Add to PC low byte jumps computed
// - Table access moves one byte via pointer
// - PC is 21 bits in three parts
// - Only add to PC low loads upper PC from latches
// - Reading PC low fills upper latches
`timescale 1ns/100ps
module cpu_fetch_execute_pipeline (
	// Clock and reset
	input  wire logic                    i_mclk,
	input  wire logic                    i_srst,
	// Program memory
	input  wire logic [15:0]             i_pmem_word,
	input  wire logic [7:0]              i_pmem_byte,
	output cpu_seq_pkg::pmem_req_t       o_pmem_req,
	// Data memory
	input  wire logic [7:0]              i_dmem_rdata,
	output cpu_seq_pkg::dmem_req_t       o_dmem_req,
	// Status
	output cpu_seq_pkg::phase_t          o_phase,
	output logic [20:0]                  o_pc,
	output logic [15:0]                  o_instr
);
	cpu_seq_pkg::phase_t phase_reg;
	logic [20:0] pc_reg;
	logic [15:0] ir_reg;
	logic [15:0] fetch_reg;
	logic        second_reg;
	logic        flush_reg;
	logic        skip_reg;
	logic [7:0]  work_reg;
	logic [7:0]  hi_latch_reg;
	logic [4:0]  up_latch_reg;
	logic [20:0] tptr_reg;
	logic [7:0]  tlat_reg;
	logic [7:0]  opnd_reg;
	cpu_seq_pkg::dmem_req_t   dreq_reg;
	cpu_seq_pkg::pmem_req_t   preq_reg;

	// Decode of the word in execution
	logic is_second;
	logic is_goto;
	logic is_bra;
	logic is_add_work_to_file;
	logic is_tst;
	logic is_tblrd;
	logic is_tblwt;
	logic is_move;
	logic exec_valid;
	logic [11:0] faddr;
	logic [7:0]  sum;
	logic [20:0] pc_next;
	logic [20:0] target;
	logic        branch;

	always_comb begin
		is_second  = ir_reg[15:12] == cpu_seq_pkg::SECOND_TOP;
		exec_valid = !second_reg && !flush_reg && !is_second;
		is_goto    = ir_reg[15:8] == cpu_seq_pkg::OP_GOTO_HI
			|| ir_reg[15:8] == cpu_seq_pkg::OP_CALL_HI
			|| ir_reg[15:8] == cpu_seq_pkg::OP_CALL_HI2;
		is_bra     = ir_reg[15:11] == cpu_seq_pkg::OP_BRA;
		is_add_work_to_file   = ir_reg[15:10] == cpu_seq_pkg::OP_ADDWK;
		is_tst     = ir_reg[15:10] == cpu_seq_pkg::OP_TSTZ;
		is_tblrd   = ir_reg == cpu_seq_pkg::OP_TBLRD;
		is_tblwt   = ir_reg == cpu_seq_pkg::OP_TBLWT;
		// Only the file move writes memory in its second cycle
		is_move    = ir_reg[15:12] == cpu_seq_pkg::OP_FMOVE;
		faddr      = {4'hf, ir_reg[7:0]};
		sum        = opnd_reg + work_reg;
		// Absolute word address into PC<20:1>
		target     = {fetch_reg[11:0], ir_reg[7:0], 1'b0};
		branch     = 1'b0;
		pc_next    = pc_reg + cpu_seq_pkg::PC_STEP;
		if (exec_valid && is_goto) begin
			branch  = 1'b1;
			pc_next = target;
		end else if (exec_valid && is_bra) begin
			branch  = 1'b1;
			// Offset counts words: byte displacement doubled
			pc_next = pc_reg - cpu_seq_pkg::PC_STEP
				+ {{9{ir_reg[10]}}, ir_reg[10:0], 1'b0};
		end else if (exec_valid && is_add_work_to_file
			&& faddr == cpu_seq_pkg::PC_LO_ADDR) begin
			branch  = 1'b1;
			// Computed jump, upper bits from latches
			pc_next = {up_latch_reg, hi_latch_reg, sum[7:1], 1'b0};
		end
	end

	// Phase generator: divide by four
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			phase_reg <= cpu_seq_pkg::PH_ONE;
		end else begin
			phase_reg <= cpu_seq_pkg::phase_t'(phase_reg + 2'b01);
		end
	end

	// Program counter, 21 bits, bit0 held zero
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			pc_reg <= cpu_seq_pkg::PC_RESET;
		end else if (phase_reg == cpu_seq_pkg::PH_FOUR && branch) begin
			pc_reg <= {pc_next[20:1], 1'b0};
		end else if (phase_reg == cpu_seq_pkg::PH_ONE) begin
			// Every cycle steps, branch or not; targets count from here
			pc_reg <= pc_reg + cpu_seq_pkg::PC_STEP;
		end
	end

	// Fetch latch and instruction register
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			fetch_reg  <= cpu_seq_pkg::NOP_WORD;
			ir_reg     <= cpu_seq_pkg::NOP_WORD;
			flush_reg  <= 1'b1;
			second_reg <= 1'b0;
			skip_reg   <= 1'b0;
		end else begin
			case (phase_reg)
				cpu_seq_pkg::PH_ONE: begin
					fetch_reg <= i_pmem_word;
				end
				cpu_seq_pkg::PH_FOUR: begin
					ir_reg     <= fetch_reg;
					// Prefetched word is discarded on a branch
					flush_reg  <= branch || skip_reg;
					// Operand word of an executed file move
					second_reg <= exec_valid && is_move;
					skip_reg   <= 1'b0;
				end
				cpu_seq_pkg::PH_THREE: begin
					skip_reg <= exec_valid && is_tst && opnd_reg == 8'h00;
				end
				default: begin
				end
			endcase
		end
	end

	// Data memory: read phase two, write phase four
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			dreq_reg <= '0;
			opnd_reg <= 8'h00;
		end else begin
			dreq_reg.rd <= 1'b0;
			dreq_reg.wr <= 1'b0;
			if (phase_reg == cpu_seq_pkg::PH_ONE && exec_valid) begin
				// A file move names its full source address
				dreq_reg.addr <= is_move ? ir_reg[11:0] : faddr;
				dreq_reg.rd   <= 1'b1;
			end
			if (phase_reg == cpu_seq_pkg::PH_TWO) begin
				// PC low reads as the address after this word
				if (faddr == cpu_seq_pkg::PC_LO_ADDR) begin
					opnd_reg <= pc_reg[7:0] - cpu_seq_pkg::PC_STEP[7:0];
				end else begin
					opnd_reg <= i_dmem_rdata;
				end
			end
			if (phase_reg == cpu_seq_pkg::PH_THREE && second_reg
				&& !flush_reg) begin
				// Second word in the IR supplies destination
				dreq_reg.addr  <= ir_reg[11:0];
				dreq_reg.wr    <= 1'b1;
				dreq_reg.wdata <= opnd_reg;
			end else if (phase_reg == cpu_seq_pkg::PH_THREE && exec_valid
				&& is_add_work_to_file && faddr != cpu_seq_pkg::PC_LO_ADDR) begin
				dreq_reg.wr    <= 1'b1;
				dreq_reg.wdata <= sum;
			end
		end
	end

	// PC latches: reading PC low copies upper PC bytes
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			hi_latch_reg <= 8'h00;
			up_latch_reg <= 5'h00;
			work_reg     <= 8'h00;
		end else if (phase_reg == cpu_seq_pkg::PH_TWO && exec_valid) begin
			if (faddr == cpu_seq_pkg::PC_LO_ADDR) begin
				hi_latch_reg <= pc_reg[15:8];
				up_latch_reg <= pc_reg[20:16];
			end
		end else if (phase_reg == cpu_seq_pkg::PH_FOUR && dreq_reg.wr) begin
			case (dreq_reg.addr)
				cpu_seq_pkg::PC_HI_ADDR: hi_latch_reg <= dreq_reg.wdata;
				cpu_seq_pkg::PC_UP_ADDR: up_latch_reg <= dreq_reg.wdata[4:0];
				cpu_seq_pkg::WORK_ADDR:  work_reg     <= dreq_reg.wdata;
				default: begin
				end
			endcase
		end
	end

	// Table pointer and latch: one byte per transfer
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			tptr_reg <= 21'h000000;
			tlat_reg <= 8'h00;
			preq_reg <= '0;
		end else begin
			preq_reg.rd   <= phase_reg == cpu_seq_pkg::PH_FOUR;
			preq_reg.wr   <= 1'b0;
			// A branch must steer the next fetch to its target
			if (phase_reg == cpu_seq_pkg::PH_FOUR && branch) begin
				preq_reg.addr <= {pc_next[20:1], 1'b0};
			end else begin
				preq_reg.addr <= pc_reg;
			end
			if (phase_reg == cpu_seq_pkg::PH_TWO && exec_valid
				&& (is_tblrd || is_tblwt)) begin
				preq_reg.addr  <= tptr_reg;
				preq_reg.rd    <= is_tblrd;
				preq_reg.wr    <= is_tblwt;
				preq_reg.wdata <= tlat_reg;
			end
			if (phase_reg == cpu_seq_pkg::PH_THREE && exec_valid && is_tblrd) begin
				tlat_reg <= i_pmem_byte;
			end
			if (phase_reg == cpu_seq_pkg::PH_FOUR && dreq_reg.wr) begin
				case (dreq_reg.addr)
					cpu_seq_pkg::PTRL_ADDR:  tptr_reg[7:0]   <= dreq_reg.wdata;
					cpu_seq_pkg::PTRH_ADDR:  tptr_reg[15:8]  <= dreq_reg.wdata;
					cpu_seq_pkg::PTRU_ADDR:  tptr_reg[20:16] <= dreq_reg.wdata[4:0];
					cpu_seq_pkg::LATCH_ADDR: tlat_reg        <= dreq_reg.wdata;
					default: begin
					end
				endcase
			end
		end
	end

	// Status outputs from flip-flops
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_phase <= cpu_seq_pkg::PH_ONE;
			o_pc    <= cpu_seq_pkg::PC_RESET;
			o_instr <= cpu_seq_pkg::NOP_WORD;
		end else begin
			o_phase <= phase_reg;
			o_pc    <= pc_reg;
			o_instr <= (exec_valid) ? ir_reg : cpu_seq_pkg::NOP_WORD;
		end
	end

	assign o_pmem_req = preq_reg;
	assign o_dmem_req = dreq_reg;
endmodule : cpu_fetch_execute_pipeline

// ==== cpu_seq_pkg.sv ====
// Package: constants and carrier types for the fetch/execute sequencer
package cpu_seq_pkg;
	localparam int PC_W         = 21;
	localparam int INSTR_W      = 16;
	localparam int DADDR_W      = 12;
	localparam logic [20:0] PC_RESET     = 21'h000000;
	localparam logic [20:0] PC_STEP      = 21'h000002;
	localparam logic [15:0] NOP_WORD     = 16'h0000;
	localparam logic [11:0] PC_LO_ADDR   = 12'hff9;
	localparam logic [11:0] PC_HI_ADDR   = 12'hffa;
	localparam logic [11:0] PC_UP_ADDR   = 12'hffb;
	localparam logic [11:0] PTRL_ADDR    = 12'hff6;
	localparam logic [11:0] PTRH_ADDR    = 12'hff7;
	localparam logic [11:0] PTRU_ADDR    = 12'hff8;
	localparam logic [11:0] LATCH_ADDR   = 12'hff5;
	localparam logic [11:0] WORK_ADDR    = 12'hfe8;
	localparam logic [3:0]  SECOND_TOP   = 4'hf;
	localparam logic [3:0]  OP_GOTO1     = 4'he;
	localparam logic [7:0]  OP_GOTO_HI   = 8'hef;
	localparam logic [7:0]  OP_CALL_HI   = 8'hec;
	localparam logic [7:0]  OP_CALL_HI2  = 8'hed;
	localparam logic [3:0]  OP_FMOVE     = 4'hc;
	localparam logic [7:0]  OP_LDPTR_HI  = 8'hee;
	localparam logic [4:0]  OP_BRA       = 5'h1a;
	localparam logic [5:0]  OP_ADDWK     = 6'h09;
	localparam logic [5:0]  OP_TSTZ      = 6'h19;
	localparam logic [15:0] OP_TBLRD     = 16'h0008;
	localparam logic [15:0] OP_TBLWT     = 16'h000c;

	// Quadrature phase of the instruction cycle
	typedef enum logic [1:0] {
		PH_ONE   = 2'b00,
		PH_TWO   = 2'b01,
		PH_THREE = 2'b10,
		PH_FOUR  = 2'b11
	} phase_t;

	// Data memory request
	typedef struct packed {
		logic [11:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} dmem_req_t;

	// Program memory request
	typedef struct packed {
		logic [20:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} pmem_req_t;
endpackage : cpu_seq_pkg

// ==== cpu_seq_monitor.sv ====
// Port checker for the fetch/execute sequencer
`timescale 1ns/100ps
module cpu_seq_monitor (
	// Clock and reset
	input wire logic              i_mclk,
	input wire logic              i_srst,
	// Watched outputs
	input cpu_seq_pkg::pmem_req_t o_pmem_req,
	input cpu_seq_pkg::dmem_req_t o_dmem_req,
	input cpu_seq_pkg::phase_t    o_phase,
	input wire logic [20:0]       o_pc,
	input wire logic [15:0]       o_instr
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	// Phases, program counter and pipeline timing
	a_phase_walk: assert property (!$past(i_srst) && !$past(i_srst, 2)
		|-> o_phase == $past(o_phase) + 2'd1) else $error("phase out of turn");
	a_reset_state: assert property ($fell(i_srst) |-> o_pc == 21'h000000
		&& o_instr == 16'h0000) else $error("bad state after reset");
	a_pc_even: assert property (o_pc[0] == 1'b0)
		else $error("odd program counter");
	a_pc_quiet: assert property ($changed(o_pc) |-> o_phase != 2'd2)
		else $error("program counter moved mid cycle");
	a_instr_hold: assert property ($changed(o_instr) |=> $stable(o_instr)[*3])
		else $error("instruction changed mid cycle");
	// Data memory access spacing
	a_rd_space: assert property (o_dmem_req.rd |=> !o_dmem_req.rd[*3])
		else $error("two reads in one cycle");
	a_wr_space: assert property (o_dmem_req.wr |=> !o_dmem_req.wr[*3])
		else $error("two writes in one cycle");
	a_rd_wr_apart: assert property (!(o_dmem_req.rd && o_dmem_req.wr))
		else $error("read and write together");
	c_read: cover property (o_dmem_req.rd);
	c_write: cover property (o_dmem_req.wr);
	c_instr: cover property ($changed(o_instr));
endmodule : cpu_seq_monitor
bind cpu_fetch_execute_pipeline cpu_seq_monitor mon_u (.i_mclk(i_mclk),
	.i_srst(i_srst), .o_pmem_req(o_pmem_req), .o_dmem_req(o_dmem_req),
	.o_phase(o_phase), .o_pc(o_pc), .o_instr(o_instr));

// ==== cpu_mem_model.sv ====
// Program and data memory model facing the sequencer
`timescale 1ns/100ps
module cpu_mem_model (
	// Clock
	input wire logic              i_mclk,
	// Requests
	input cpu_seq_pkg::pmem_req_t i_preq,
	input cpu_seq_pkg::dmem_req_t i_dreq,
	// Answers
	output logic [15:0]           o_word,
	output logic [7:0]            o_byte,
	output logic [7:0]            o_rdata
);
	logic [15:0] pm [0:255];
	logic [7:0]  dm [0:4095];
	logic [15:0] w;
	// Data starts cleared
	initial begin
		for (int i = 0; i < 4096; i++) dm[i] = 8'h00;
		o_word = 16'h0000;
		o_byte = 8'h00;
		o_rdata = 8'h00;
	end
	// Answers change off the sampling edge
	always @(negedge i_mclk) begin
		w = pm[i_preq.addr[8:1]];
		o_word <= w;
		o_byte <= i_preq.addr[0] ? w[15:8] : w[7:0]; // Low byte even
		o_rdata <= dm[i_dreq.addr];
	end
	// Destination write
	always @(posedge i_mclk) if (i_dreq.wr === 1'b1) dm[i_dreq.addr] <= i_dreq.wdata;
endmodule : cpu_mem_model

// ==== cpu_fetch_execute_pipeline_bench.sv ====
// Self-checking bench for the fetch/execute sequencer
`timescale 1ns/100ps
module cpu_fetch_execute_pipeline_bench;
	logic                   i_mclk;
	logic                   i_srst;
	logic [15:0]            pm_word;
	logic [7:0]             pm_byte;
	logic [7:0]             dm_rdata;
	cpu_seq_pkg::pmem_req_t preq;
	cpu_seq_pkg::dmem_req_t dreq;
	cpu_seq_pkg::phase_t    phase;
	logic [20:0]            pc;
	logic [15:0]            instr;
	int                     fail_count;
	int                     check_count;
	bit                     seen [logic [15:0]];
	bit                     rd_at [logic [11:0]];
	bit                     wr_at [logic [11:0]];
	localparam logic [15:0] PROG [0:19] = '{16'h0000, 16'h2610, 16'hef08,
		16'hf000, 16'h0e11, 16'h0000, 16'h0000, 16'h0000, 16'h0e22, 16'hd002,
		16'h0e33, 16'h0e44, 16'h0e55, 16'h6620, 16'hc020, 16'hf456, 16'hc010,
		16'hf123, 16'h0e66, 16'hd7ff};
	// Clock
	initial i_mclk = 1'b0;
	always #50 i_mclk = ~i_mclk;
	cpu_fetch_execute_pipeline dut_u (.i_mclk(i_mclk), .i_srst(i_srst),
		.i_pmem_word(pm_word), .i_pmem_byte(pm_byte), .o_pmem_req(preq),
		.i_dmem_rdata(dm_rdata), .o_dmem_req(dreq), .o_phase(phase),
		.o_pc(pc), .o_instr(instr));
	cpu_mem_model mem_u (.i_mclk(i_mclk), .i_preq(preq), .i_dreq(dreq),
		.o_word(pm_word), .o_byte(pm_byte), .o_rdata(dm_rdata));
	// Record executed words and data accesses
	always @(posedge i_mclk) begin
		seen[instr] = 1'b1;
		if (dreq.rd === 1'b1) rd_at[dreq.addr] = 1'b1;
		if (dreq.wr === 1'b1) wr_at[dreq.addr] = 1'b1;
	end
	task automatic check(input bit ok, input string msg);
		check_count++;
		if (!ok) begin
			fail_count++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask : check
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : complete_run
	// Reset state: address zero, empty pipeline
	task automatic t_reset;
		repeat (12) @(negedge i_mclk);
		i_srst <= 1'b0;
		check(pc === 21'h000000 && instr === 16'h0000, "reset state");
	endtask : t_reset
	// Straight-line code steps two bytes per instruction cycle
	task automatic t_rate;
		for (int n = 0; n < 20 && pc !== 21'h000002; n++) @(negedge i_mclk);
		repeat (4) @(negedge i_mclk);
		check(pc === 21'h000004, "sequential step");
	endtask : t_rate
	// Goto, branch, skip over two-word and data access
	task automatic t_flow;
		for (int n = 0; n < 400 && !seen.exists(16'h0e66); n++)
			@(negedge i_mclk);
		check(rd_at.exists(12'hf10) && wr_at.exists(12'hf10), "rmw");
		check(seen.exists(16'h0e22) && !seen.exists(16'h0e11), "goto");
		check(seen.exists(16'h0e55), "branch target");
		check(!seen.exists(16'h0e33) && !seen.exists(16'h0e44), "flush");
		check(!wr_at.exists(12'h456) && !seen.exists(16'hc020), "skip");
		check(rd_at.exists(12'h010) && wr_at.exists(12'h123), "move");
		check(!seen.exists(16'hf456) && !seen.exists(16'hf123), "2nd");
		check(seen.exists(16'h0e66), "end reached");
	endtask : t_flow
	// Watchdog
	initial begin
		#200000;
		fail_count++;
		$display("MISMATCH %0t timeout", $time);
		complete_run();
	end
	// Main sequence
	initial begin
		i_srst = 1'b1;
		for (int i = 0; i < 256; i++) mem_u.pm[i] = i < 20 ? PROG[i] : 16'h0000;
		t_reset();
		t_rate();
		t_flow();
		complete_run();
	end
endmodule : cpu_fetch_execute_pipeline_bench
